// ---- design/acc_edge.sv ----
// Per-comparator output shaping and edge-detect event generation.
// Assumes a synchronised raw comparator level on the same clock.
`timescale 1ns/1ns
`default_nettype none
module acc_edge (
  input  wire logic          ref_clk, // System clock
  input  wire logic          rst_n,   // Asynchronous reset, active low
  input  wire logic          raw_in,  // Synchronised analog result
  input  wire acc_pkg::acc_ctl_s ctl, // Control bundle
  output logic               out_reg, // Polarity-corrected output
  output logic               ev_pulse // One-cycle event strobe
);
  logic out_next; // Next output value
  logic rise;     // Output rose
  logic fall;     // Output fell

  // A disabled comparator reads low whatever the polarity; polarity applies only while enabled
  assign out_next = ctl.on & (raw_in ^ ctl.inv);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      out_reg <= 1'b0;
    else
      out_reg <= out_next;
  end

  // Edges seen on the corrected output, so inversion does not swap the sense
  assign rise = out_next & ~out_reg;
  assign fall = ~out_next & out_reg;

  // Event select decode; code zero means no events
  always_comb
  begin
    case (ctl.evsel)
      acc_pkg::ACC_EV_RISE: ev_pulse = rise;
      acc_pkg::ACC_EV_FALL: ev_pulse = fall;
      acc_pkg::ACC_EV_ANY:  ev_pulse = rise | fall;
      default:              ev_pulse = 1'b0;
    endcase
  end

  // Polarity must not change which edge is flagged
  a_edge_sense: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctl.evsel == acc_pkg::ACC_EV_RISE && ev_pulse) |-> (out_next && !out_reg))
    else $error("rise select flagged a non-rising edge");
  a_edge_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctl.evsel == 2'h0) |-> !ev_pulse)
    else $error("event raised with events disabled");
endmodule : acc_edge
`default_nettype wire

// ---- design/acc_pkg.sv ----
// Package for the comparator control/status block: offsets, bit positions, types.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz clock.
package acc_pkg;
  // Register byte offsets
  localparam logic [3:0] ACC_OFF_CTRL1  = 4'h0; // Control register, comparator one
  localparam logic [3:0] ACC_OFF_CTRL2  = 4'h4; // Control register, comparator two
  localparam logic [3:0] ACC_OFF_STATUS = 4'h8; // Shared status register
  localparam logic [3:0] ACC_OFF_IRQST  = 4'hc; // Sticky interrupt status
  localparam logic [4:0] ACC_OFF_MASK   = 5'h10; // Interrupt mask
  // Control register fields
  localparam int ACC_CTL_ON   = 15; // Module enable
  localparam int ACC_CTL_OE   = 14; // Output pin enable
  localparam int ACC_CTL_INV  = 13; // Output polarity
  localparam int ACC_CTL_EVH  = 7;  // Event select high bit
  localparam int ACC_CTL_EVL  = 6;  // Event select low bit
  localparam logic [15:0] ACC_CTL_WMASK = 16'he0c0; // Writable control bits
  localparam logic [15:0] ACC_CTL_RST   = 16'h0000; // Control reset value
  // Status register fields
  localparam int ACC_ST_IDLE = 15; // Stop-in-idle control
  localparam int ACC_ST_EV2  = 9;  // Event flag, comparator two
  localparam int ACC_ST_EV1  = 8;  // Event flag, comparator one
  localparam int ACC_ST_OUT2 = 1;  // Live output, comparator two
  localparam int ACC_ST_OUT1 = 0;  // Live output, comparator one
  // Event select codes
  localparam logic [1:0] ACC_EV_RISE = 2'h1; // Low-to-high edge
  localparam logic [1:0] ACC_EV_FALL = 2'h2; // High-to-low edge
  localparam logic [1:0] ACC_EV_ANY  = 2'h3; // Either edge
  // AXI responses
  localparam logic [1:0] ACC_RESP_OK  = 2'h0;
  localparam logic [1:0] ACC_RESP_ERR = 2'h2;
  // Per-comparator control bundle
  typedef struct packed {
    logic       on;
    logic       oe;
    logic       inv;
    logic [1:0] evsel;
  } acc_ctl_s;
endpackage : acc_pkg

// ---- design/acc_sync.sv ----
// Two-flop synchroniser for a single asynchronous level.
// Assumes the input comes from outside the ref_clk domain.
`timescale 1ns/1ns
`default_nettype none
module acc_sync (
  input  wire logic ref_clk,  // System clock
  input  wire logic rst_n,    // Asynchronous reset, active low
  input  wire logic async_in, // Level from outside
  output logic      sync_out  // Level safe to use
);
  logic meta_reg; // First stage, read only by the second stage

  // Two stages, reset to zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : acc_sync
`default_nettype wire

// ---- design/acc_top.sv ----
// Top of the dual comparator control/status block with AXI4-Lite registers.
// Assumes raw comparator levels arrive asynchronously and the idle level is a pin.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Output-enable bit 14 drives dedicated pin
// - Enable bit 15 cleared disables comparator
// - Clearing output-enable returns pin to digital
// - Event select bits 7:6 pick edge
// - Polarity bit 13 inverts, edge sense kept
// - Stop-in-idle bit 15 suppresses idle interrupts
// - Status bits 9,8 are hardware event flags
// - Status bits 1,0 mirror live outputs
// - Unimplemented status bits zero, reset zero
module acc_top (
  input  wire logic        ref_clk,        // System clock, 25 MHz
  input  wire logic        rst_n,          // Asynchronous reset, active low
  input  wire logic        cmp_raw_one,    // Analog result, comparator one
  input  wire logic        cmp_raw_two,    // Analog result, comparator two
  input  wire logic        cpu_idle,       // Device in idle mode
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [4:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             cmp_one_output_pin,    // Pin level, comparator one
  output logic             cmp_one_output_pin_oe, // Pin taken by comparator one
  output logic             cmp_two_output_pin,    // Pin level, comparator two
  output logic             cmp_two_output_pin_oe, // Pin taken by comparator two
  output logic             irq                    // Level interrupt
);
  localparam int NCMP = 2; // Comparators in the block
  logic [15:0] cmp_control_reg [NCMP]; // Control registers
  acc_pkg::acc_ctl_s ctl [NCMP];       // Decoded control
  logic [NCMP-1:0] raw_sync;           // Synchronised raw levels
  logic [NCMP-1:0] out_live;           // Corrected outputs
  logic [NCMP-1:0] ev_pulse;           // Edge strobes
  logic [NCMP-1:0] ev_flag_reg;        // Hardware event flags
  logic [NCMP-1:0] irq_st_reg;         // Sticky interrupt status
  logic [NCMP-1:0] irq_mask_reg;       // Interrupt mask
  logic            cmp_stop_in_idle;   // Stop-in-idle control
  logic            idle_sync;          // Synchronised idle level
  logic [NCMP-1:0] raw_in;             // Raw pins as a vector
  logic [NCMP-1:0] ev_gated;           // Events allowed to interrupt
  logic [15:0]     status_word;        // Status register image
  // Write path holding registers
  logic            aw_held_reg;
  logic [4:0]      aw_addr_reg;
  logic            w_held_reg;
  logic [31:0]     w_data_reg;
  logic [3:0]      w_strb_reg;
  logic            do_write;
  logic [NCMP-1:0] w1c_bits;            // Interrupt bits being cleared
  // Word offset compare shared by read and write decode
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a[4:2] == off[4:2]);
  endfunction : hit
  assign raw_in = {cmp_raw_two, cmp_raw_one};
  // Per-comparator synchroniser, shaping and event detect
  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi++)
    begin : g_cmp
      assign ctl[gi] = '{on:    cmp_control_reg[gi][acc_pkg::ACC_CTL_ON],
                         oe:    cmp_control_reg[gi][acc_pkg::ACC_CTL_OE],
                         inv:   cmp_control_reg[gi][acc_pkg::ACC_CTL_INV],
                         evsel: cmp_control_reg[gi][acc_pkg::ACC_CTL_EVH:acc_pkg::ACC_CTL_EVL]};
      acc_sync u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (raw_in[gi]),
        .sync_out (raw_sync[gi])
      );
      acc_edge u_edge (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .raw_in   (raw_sync[gi]),
        .ctl      (ctl[gi]),
        .out_reg  (out_live[gi]),
        .ev_pulse (ev_pulse[gi])
      );
    end
  endgenerate
  acc_sync u_idle_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (cpu_idle),
    .sync_out (idle_sync)
  );
  // Stop-in-idle masks interrupts only; the flags still follow edges
  assign ev_gated = ev_pulse & {NCMP{~(cmp_stop_in_idle & idle_sync)}};
  // Write address and data are taken independently, in either order
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 5'h00;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && !aw_held_reg && !s_axi_awready)
      s_axi_awready <= 1'b1;
    else if (s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_held_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && !w_held_reg && !s_axi_wready)
      s_axi_wready <= 1'b1;
    else if (s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_held_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_reg <= 1'b0;
  end
  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acc_pkg::ACC_RESP_OK;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_reg > acc_pkg::ACC_OFF_MASK) ?
                      acc_pkg::ACC_RESP_ERR : acc_pkg::ACC_RESP_OK;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
  // Control registers; only the documented fields are writable
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_control_reg[0] <= acc_pkg::ACC_CTL_RST;
      cmp_control_reg[1] <= acc_pkg::ACC_CTL_RST;
    end
    else if (do_write)
    begin
      for (int i = 0; i < NCMP; i++)
      begin
        if (hit(aw_addr_reg, {1'b0, acc_pkg::ACC_OFF_CTRL1} + 5'(4 * i)))
        begin
          if (w_strb_reg[0])
            cmp_control_reg[i][7:0] <= w_data_reg[7:0] & acc_pkg::ACC_CTL_WMASK[7:0];
          if (w_strb_reg[1])
            cmp_control_reg[i][15:8] <= w_data_reg[15:8] & acc_pkg::ACC_CTL_WMASK[15:8];
        end
      end
    end
  end
  // Stop-in-idle and mask registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_stop_in_idle <= 1'b0;
      irq_mask_reg     <= '0;
    end
    else if (do_write)
    begin
      if (hit(aw_addr_reg, {1'b0, acc_pkg::ACC_OFF_STATUS}) && w_strb_reg[1])
        cmp_stop_in_idle <= w_data_reg[acc_pkg::ACC_ST_IDLE];
      if (hit(aw_addr_reg, acc_pkg::ACC_OFF_MASK) && w_strb_reg[0])
        irq_mask_reg <= w_data_reg[NCMP-1:0];
    end
  end
  // Event flags follow every selected edge, cleared when the comparator is switched off
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ev_flag_reg <= '0;
    else
    begin
      for (int i = 0; i < NCMP; i++)
      begin
        if (ev_pulse[i])
          ev_flag_reg[i] <= 1'b1;
        else if (!ctl[i].on)
          ev_flag_reg[i] <= 1'b0;
      end
    end
  end
  // Sticky interrupt bits: write one to clear, a new event wins
  assign w1c_bits = (do_write && hit(aw_addr_reg, {1'b0, acc_pkg::ACC_OFF_IRQST}) && w_strb_reg[0])
                    ? w_data_reg[NCMP-1:0] : '0;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_st_reg <= '0;
    else
      irq_st_reg <= (irq_st_reg & ~w1c_bits) | ev_gated;
  end
  // Interrupt line from the next sticky value, so it is not a cycle late
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |((irq_st_reg & ~w1c_bits | ev_gated) & irq_mask_reg);
  end

  // Status image; bits not listed read zero
  always_comb
  begin
    status_word = 16'h0000;
    status_word[acc_pkg::ACC_ST_IDLE] = cmp_stop_in_idle;
    status_word[acc_pkg::ACC_ST_EV2]  = ev_flag_reg[1];
    status_word[acc_pkg::ACC_ST_EV1]  = ev_flag_reg[0];
    status_word[acc_pkg::ACC_ST_OUT2] = out_live[1];
    status_word[acc_pkg::ACC_ST_OUT1] = out_live[0];
  end

  // Read channel: one cycle to accept, data the cycle after
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= acc_pkg::ACC_RESP_OK;
    end
    else if (s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= acc_pkg::ACC_RESP_OK;
      if (hit(s_axi_araddr, {1'b0, acc_pkg::ACC_OFF_CTRL1}))
        s_axi_rdata <= {16'h0000, cmp_control_reg[0]};
      else if (hit(s_axi_araddr, {1'b0, acc_pkg::ACC_OFF_CTRL2}))
        s_axi_rdata <= {16'h0000, cmp_control_reg[1]};
      else if (hit(s_axi_araddr, {1'b0, acc_pkg::ACC_OFF_STATUS}))
        s_axi_rdata <= {16'h0000, status_word};
      else if (hit(s_axi_araddr, {1'b0, acc_pkg::ACC_OFF_IRQST}))
        s_axi_rdata <= {30'h0, irq_st_reg};
      else if (hit(s_axi_araddr, acc_pkg::ACC_OFF_MASK))
        s_axi_rdata <= {30'h0, irq_mask_reg};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= acc_pkg::ACC_RESP_ERR;
      end
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid)
      s_axi_arready <= 1'b1;
  end
  // Pin takeover follows the output-enable bit alone, so clearing it frees the pin
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_one_output_pin    <= 1'b0;
      cmp_one_output_pin_oe <= 1'b0;
      cmp_two_output_pin    <= 1'b0;
      cmp_two_output_pin_oe <= 1'b0;
    end
    else
    begin
      cmp_one_output_pin    <= out_live[0];
      cmp_one_output_pin_oe <= ctl[0].oe;
      cmp_two_output_pin    <= out_live[1];
      cmp_two_output_pin_oe <= ctl[1].oe;
    end
  end
  a_pin_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctl[0].oe |=> !cmp_one_output_pin_oe)
    else $error("pin one still taken after output enable cleared");
  a_pin_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctl[1].oe |=> cmp_two_output_pin_oe)
    else $error("pin two not taken while output enable set");
  a_off_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctl[0].on |=> !out_live[0])
    else $error("disabled comparator output not low");
  a_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ev_pulse[1] |=> status_word[acc_pkg::ACC_ST_EV2])
    else $error("event flag two not set after event");
  a_live_copy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_word[acc_pkg::ACC_ST_OUT1] == out_live[0])
    else $error("status output bit differs from live output");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmp_stop_in_idle && idle_sync && irq_st_reg == '0) |=> irq_st_reg == '0)
    else $error("interrupt status set during stopped idle");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ev_gated[0] && irq_mask_reg[0]) |=> irq)
    else $error("unmasked event did not raise interrupt");
  a_stat_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_word[14:10] == 5'h00 && status_word[7:2] == 6'h00)
    else $error("unimplemented status bits not zero");
endmodule : acc_top
`default_nettype wire

// ---- test/tb_analog_comparator_control_status.sv ----
// Self-checking bench for the dual comparator control/status block.
// Assumes acc_pkg and acc_top are compiled first; one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_analog_comparator_control_status;
  localparam logic [4:0] A_C1 = {1'b0, acc_pkg::ACC_OFF_CTRL1};  // Control one
  localparam logic [4:0] A_C2 = {1'b0, acc_pkg::ACC_OFF_CTRL2};  // Control two
  localparam logic [4:0] A_ST = {1'b0, acc_pkg::ACC_OFF_STATUS}; // Status
  localparam logic [4:0] A_IS = {1'b0, acc_pkg::ACC_OFF_IRQST};  // Sticky flags
  localparam logic [4:0] A_MK = acc_pkg::ACC_OFF_MASK;           // Mask
  logic        ref_clk;                 // System clock
  logic        rst_n;                   // Reset, active low
  logic [1:0]  raw;                     // Raw levels, bit 0 is comparator one
  logic        cpu_idle;                // Idle mode level
  logic        awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr; // Handshakes
  logic [4:0]  aw, ar;                  // Addresses
  logic [31:0] wd, rd, d;               // Bus data and scratch
  logic [1:0]  bresp, rresp, r, ev;     // Responses, scratch, event code
  logic [1:0]  pin, pin_oe;             // Pin levels and takeover
  logic        irq, v, inv;             // Interrupt and scratch bits
  logic        m_idle;                  // Expected stop-in-idle bit
  logic [1:0]  m_ev, m_out;             // Expected flags and live outputs
  int          bad_count, cmp_count, i, seed;

  acc_top DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmp_raw_one(raw[0]), .cmp_raw_two(raw[1]),
    .cpu_idle(cpu_idle),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(aw),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ar),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .cmp_one_output_pin(pin[0]), .cmp_one_output_pin_oe(pin_oe[0]),
    .cmp_two_output_pin(pin[1]), .cmp_two_output_pin_oe(pin_oe[1]), .irq(irq)
  );

  // Free-running clock, 40 ns period
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  // Verdict, reached from the main sequence and the watchdog
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic fail(input string s);
    bad_count++;
    $display("MISMATCH t=%0t %s", $time, s);
  endtask : fail

  // Compare tasks, four-state so an unknown never matches
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) fail($sformatf("word %h expected %h", g, e));
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) fail($sformatf("bit %b expected %b", g, e));
  endtask : chk_bit

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    cmp_count++;
    if (g !== e) fail($sformatf("resp %h expected %h", g, e));
  endtask : chk_resp

  // Write: address and data offered together, each dropped once taken
  task automatic axi_w(input logic [4:0] a, input logic [31:0] x, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge ref_clk);
    aw <= a;
    wd <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end
    while (bv !== 1'b1 && n < 64);
    rs = bresp;
    br <= 1'b0;
    if (bv !== 1'b1) fail("write response missing");
  endtask : axi_w

  // Read: rready held until rvalid is sampled
  task automatic axi_r(input logic [4:0] a, output logic [31:0] x, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge ref_clk);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end
    while (rv !== 1'b1 && n < 64);
    x = rd;
    rs = rresp;
    rr <= 1'b0;
    if (rv !== 1'b1) fail("read data missing");
  endtask : axi_r

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] x;
    logic [1:0]  rs;
    axi_r(a, x, rs);
    chk_resp(rs, acc_pkg::ACC_RESP_OK);
    chk_word(x, e);
  endtask : rd_chk

  // Short settle after a write so registered outputs have moved
  task automatic wr_ok(input logic [4:0] a, input logic [31:0] x);
    logic [1:0] rs;
    axi_w(a, x, rs);
    chk_resp(rs, acc_pkg::ACC_RESP_OK);
    repeat (3) @(posedge ref_clk);
  endtask : wr_ok

  // Raw level change; 8 cycles covers synchroniser plus output flops
  task automatic drive(input int k, input logic x);
    @(posedge ref_clk);
    raw[k] <= x;
    repeat (8) @(posedge ref_clk);
  endtask : drive

  function automatic logic [31:0] ctl(input logic on, oe, iv, input logic [1:0] e);
    return {16'h0, on, oe, iv, 5'h0, e, 6'h0};
  endfunction : ctl

  function automatic logic [31:0] st_exp();
    return {16'h0, m_idle, 5'h0, m_ev, 6'h0, m_out};
  endfunction : st_exp

  function automatic logic [31:0] bit_at(input int k, input logic b);
    return b ? (32'h1 << k) : 32'h0;
  endfunction : bit_at

  function automatic logic [4:0] ca(input int k);
    return (k != 0) ? A_C2 : A_C1;
  endfunction : ca

  // Watchdog, well beyond the few thousand cycles the run needs
  initial
  begin
    #2000000;
    fail("timeout");
    end_of_test();
  end

  // Main sequence
  initial
  begin
    {bad_count, cmp_count, m_idle, m_ev, m_out} = '0;
    {rst_n, raw, cpu_idle, awv, wv, br, arv, rr, aw, ar, wd} = '0;
    seed = $urandom(32'h7ecac2bb);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(A_C1, 32'h0);
    rd_chk(A_C2, 32'h0);
    rd_chk(A_ST, st_exp());
    rd_chk(A_IS, 32'h0);
    rd_chk(A_MK, 32'h0);
    // Control fields: all-ones corner, then random words
    for (int k = 0; k < 6; k++)
    begin
      d = (k == 0) ? 32'hffffffff : $urandom;
      wr_ok(ca(k % 2), d);
      rd_chk(ca(k % 2), d & {16'h0, acc_pkg::ACC_CTL_WMASK});
    end
    wr_ok(A_C1, 32'h0);
    wr_ok(A_C2, 32'h0);
    wr_ok(A_IS, 32'h3);
    // Unmapped offset is refused and changes nothing
    axi_w(5'h14, 32'hffff, r);
    chk_resp(r, acc_pkg::ACC_RESP_ERR);
    axi_r(5'h14, d, r);
    chk_resp(r, acc_pkg::ACC_RESP_ERR);
    rd_chk(A_C1, 32'h0);
    // Only the idle bit of status is writable
    wr_ok(A_ST, 32'hffffffff);
    m_idle = 1'b1;
    rd_chk(A_ST, st_exp());
    wr_ok(A_ST, 32'h0);
    m_idle = 1'b0;
    // Pin takeover and polarity, random levels
    for (int k = 0; k < 8; k++)
    begin
      i = k % 2;
      inv = 1'($urandom);
      v = 1'($urandom);
      wr_ok(ca(i), ctl(1'b1, 1'b1, inv, 2'h0));
      drive(i, v);
      m_out[i] = v ^ inv;
      rd_chk(A_ST, st_exp());
      chk_bit(pin[i], v ^ inv);
      chk_bit(pin_oe[i], 1'b1);
      wr_ok(ca(i), ctl(1'b1, 1'b0, inv, 2'h0));
      chk_bit(pin_oe[i], 1'b0);
      wr_ok(ca(i), ctl(1'b1, 1'b1, inv, 2'h0));
      wr_ok(ca(i), 32'h0);
      chk_bit(pin_oe[i], 1'b0);
      drive(i, 1'b0);
      m_out[i] = 1'b0;
    end
    // Every event code, both polarities, both comparators; both interrupts enabled
    wr_ok(A_MK, 32'h3);
    for (int k = 0; k < 16; k++)
    begin
      i = k / 8;
      inv = k[0];
      ev = k[2:1];
      wr_ok(ca(i), ctl(1'b1, 1'b0, inv, 2'h0));
      drive(i, inv);
      wr_ok(ca(i), ctl(1'b1, 1'b0, inv, ev));
      drive(i, ~inv);
      m_ev[i] = ev[0];
      m_out[i] = 1'b1;
      rd_chk(A_ST, st_exp());
      rd_chk(A_IS, bit_at(i, ev[0]));
      chk_bit(irq, ev[0]);
      wr_ok(A_IS, 32'h3);
      drive(i, inv);
      m_ev[i] = ev[0] | ev[1];
      m_out[i] = 1'b0;
      rd_chk(A_ST, st_exp());
      rd_chk(A_IS, bit_at(i, ev[1]));
      chk_bit(irq, ev[1]);
      wr_ok(A_IS, 32'h3);
      wr_ok(ca(i), 32'h0);
      drive(i, 1'b0);
      m_ev[i] = 1'b0;
      rd_chk(A_ST, st_exp());
    end
    // Stop-in-idle keeps the flag but holds back the interrupt
    wr_ok(A_ST, 32'h8000);
    m_idle = 1'b1;
    cpu_idle <= 1'b1;
    wr_ok(A_C1, ctl(1'b1, 1'b0, 1'b0, 2'h3));
    drive(0, 1'b1);
    m_ev[0] = 1'b1;
    m_out[0] = 1'b1;
    rd_chk(A_ST, st_exp());
    rd_chk(A_IS, 32'h0);
    chk_bit(irq, 1'b0);
    cpu_idle <= 1'b0;
    drive(0, 1'b0);
    m_out[0] = 1'b0;
    rd_chk(A_IS, 32'h1);
    chk_bit(irq, 1'b1);
    // A mask bit of one lets that comparator interrupt; write-one clears
    wr_ok(A_MK, 32'h2);
    chk_bit(irq, 1'b0);
    rd_chk(A_MK, 32'h2);
    wr_ok(A_MK, 32'h1);
    chk_bit(irq, 1'b1);
    wr_ok(A_IS, 32'h1);
    chk_bit(irq, 1'b0);
    rd_chk(A_IS, 32'h0);
    // Idle with stop-in-idle off still interrupts
    wr_ok(A_ST, 32'h0);
    m_idle = 1'b0;
    cpu_idle <= 1'b1;
    drive(0, 1'b1);
    m_out[0] = 1'b1;
    rd_chk(A_IS, 32'h1);
    chk_bit(irq, 1'b1);
    end_of_test();
  end
endmodule : tb_analog_comparator_control_status
`default_nettype wire
